// ==== dv/tb_two_wire_config_slave.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_two_wire_config_slave;
    import twcs_pkg::*;
    logic ref_clk_i = 1'b0;
    logic arst_n_i = 1'b1;
    logic req_valid_i = 1'b0;
    twcs_mode_t req_mode_i = MODE_WR;
    logic [7:0] req_reg_i = 8'h00;
    logic [7:0] req_wdata_i = 8'h00;
    logic req_ready_o, done_o, nack_o, cfg_wr_o, cfg_wr_b;
    logic [7:0] rdata_o, cfg_data_o, cfg_data_b;
    logic [AW-1:0] cfg_addr_o, cfg_addr_b;
    logic [7:0] bank [NUM_REGS];
    int num_errors = 0;
    int n_compared = 0;
    int wr_cnt = 0;
    int wr_cnt_b = 0;
    twcs_if u_if ();
    twcs_if u_if2 ();
    // 250 MHz clock
    always #2 ref_clk_i = ~ref_clk_i;
    // master and slave face each other; a second slave faces the bench driver
    twcs_master i_twcs_master (.link(u_if), .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .req_valid_i(req_valid_i),
        .req_ready_o(req_ready_o), .req_mode_i(req_mode_i), .req_reg_i(req_reg_i), .req_wdata_i(req_wdata_i),
        .done_o(done_o), .nack_o(nack_o), .rdata_o(rdata_o));
    twcs_slave i_twcs_slave (.link(u_if), .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .cfg_wr_o(cfg_wr_o),
        .cfg_addr_o(cfg_addr_o), .cfg_data_o(cfg_data_o));
    twcs_slave i_twcs_slave_b (.link(u_if2), .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .cfg_wr_o(cfg_wr_b),
        .cfg_addr_o(cfg_addr_b), .cfg_data_o(cfg_data_b));
    twcs_chk u_chk (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .scl(u_if.scl), .m_sda_oe(u_if.m_sda_oe),
        .s_sda_oe(u_if.s_sda_oe), .sda(u_if.sda));
    // count write pulses seen on both slaves
    always @(posedge ref_clk_i) begin
        if (cfg_wr_o === 1'b1) wr_cnt++;
        if (cfg_wr_b === 1'b1) wr_cnt_b++;
    end
    task automatic end_of_test;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask : chk
    // one request through the master, waiting for done under a bound
    task automatic do_req(input twcs_mode_t m, input logic [7:0] r, input logic [7:0] w);
        int n;
        n = 0;
        chk("req_ready_o", 8'h01, {7'h00, req_ready_o});
        req_mode_i = m;
        req_reg_i = r;
        req_wdata_i = w;
        req_valid_i = 1'b1;
        @(negedge ref_clk_i);
        req_valid_i = 1'b0;
        while (done_o !== 1'b1 && n < 2000) begin
            @(negedge ref_clk_i);
            n++;
        end
        if (n >= 2000) begin
            $display("[ERR] done_o expected 1 seen timeout");
            num_errors++;
            end_of_test();
        end
    endtask : do_req
    // writable only above the read-only block and with a zero-led register byte
    task automatic write_expect(input logic [7:0] r, input logic [7:0] w);
        int c0;
        logic ok;
        c0 = wr_cnt;
        ok = (r[7:5] == REG_HI_ZERO) && (r[4:0] > RO_LAST);
        do_req(MODE_WR, r, w);
        chk("nack_o", {7'h00, r[7:5] != REG_HI_ZERO}, {7'h00, nack_o});
        chk("cfg_wr_o count", 8'(c0 + int'(ok)), 8'(wr_cnt));
        if (ok) bank[r[4:0]] = w;
    endtask : write_expect
    task automatic sc_reset_values;
        for (int a = 0; a < NUM_REGS; a++) begin
            do_req(MODE_RD_PTR, 8'(a), 8'h00);
            chk("rdata_o", bank[a], rdata_o);
            chk("nack_o", 8'h00, {7'h00, nack_o});
        end
    endtask : sc_reset_values
    task automatic sc_write_rw;
        write_expect(8'h0C, 8'h5A);
        chk("cfg_addr_o", 8'h0C, {3'h0, cfg_addr_o});
        chk("cfg_data_o", 8'h5A, cfg_data_o);
        do_req(MODE_RD_CUR, 8'h00, 8'h00);
        chk("rdata_o", 8'h5A, rdata_o);
        write_expect(8'h1F, 8'hA5);
        for (int i = 0; i < 2; i++) begin
            do_req(MODE_RD_CUR, 8'h00, 8'h00);
            chk("rdata_o", bank[31], rdata_o);
        end
    endtask : sc_write_rw
    task automatic sc_write_ro;
        logic [7:0] r;
        for (int i = 0; i < 2; i++) begin
            r = (i == 0) ? 8'h00 : 8'h0B;
            write_expect(r, 8'h3C);
            do_req(MODE_RD_PTR, r, 8'h00);
            chk("rdata_o", bank[r[4:0]], rdata_o);
        end
    endtask : sc_write_ro
    task automatic sc_bad_reg;
        do_req(MODE_RD_PTR, 8'h05, 8'h00);
        chk("rdata_o", FREQ_LO, rdata_o);
        write_expect(8'h20, 8'h77);
        write_expect(8'hE5, 8'h11);
        do_req(MODE_RD_CUR, 8'h00, 8'h00);
        chk("rdata_o", FREQ_LO, rdata_o);
    endtask : sc_bad_reg
    // bench-made link clock, 80 ns per bit, for the second slave
    task automatic bb_bit(input logic low, output logic seen);
        u_if2.m_sda_oe = low;
        #20 u_if2.scl = 1'b1;
        #20 seen = u_if2.sda;
        #20 u_if2.scl = 1'b0;
        #20;
    endtask : bb_bit
    task automatic bb_byte(input logic [7:0] b, input logic m_ack, output logic [7:0] got, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bb_bit(~b[i], s);
            got[i] = s;
        end
        bb_bit(m_ack, ack);
    endtask : bb_byte
    task automatic bb_frame(input logic [7:0] b0, input logic [7:0] b1, input int nb, output logic [7:0] g,
        output logic [2:0] acks);
        u_if2.m_sda_oe = 1'b0;
        #20 u_if2.m_sda_oe = 1'b1;
        #20 u_if2.scl = 1'b0;
        #20;
        bb_byte(b0, 1'b0, g, acks[0]);
        bb_byte(b1, 1'b0, g, acks[1]);
        if (nb > 2) bb_byte(8'h99, 1'b0, g, acks[2]);
        u_if2.m_sda_oe = 1'b1;
        #20 u_if2.scl = 1'b1;
        #20 u_if2.m_sda_oe = 1'b0;
        #20;
    endtask : bb_frame
    task automatic sc_link_b;
        logic [7:0] g;
        logic [2:0] a;
        int c0;
        c0 = wr_cnt_b;
        bb_frame(8'h7C, 8'h0C, 3, g, a);
        chk("foreign acks", 8'h07, {5'h00, a});
        chk("cfg_wr_b count", 8'(c0), 8'(wr_cnt_b));
        bb_frame(8'h7E, 8'h0D, 3, g, a);
        chk("own acks", 8'h00, {5'h00, a});
        chk("cfg_wr_b count", 8'(c0 + 1), 8'(wr_cnt_b));
        chk("cfg_addr_b", 8'h0D, {3'h0, cfg_addr_b});
        chk("cfg_data_b", 8'h99, cfg_data_b);
        // current read, then leave the data unacknowledged
        bb_frame(8'h7F, 8'hFF, 2, g, a);
        chk("read address ack", 8'h00, {7'h00, a[0]});
        chk("read data", 8'h99, g);
        chk("released after data", 8'h01, {7'h00, a[1]});
    endtask : sc_link_b
    initial begin
        u_if2.scl = 1'b1;
        u_if2.m_sda_oe = 1'b0;
        // reset must fall as a real edge: the start flop clocks only on data falls
        #1 arst_n_i = 1'b0;
        for (int a = 0; a < NUM_REGS; a++) bank[a] = 8'h00;
        bank[0] = ID_VEND_LO;
        bank[1] = ID_VEND_HI;
        bank[2] = ID_DEV_LO;
        bank[3] = ID_DEV_HI;
        bank[4] = ID_REV;
        bank[5] = FREQ_LO;
        bank[6] = FREQ_HI;
        repeat (16) @(negedge ref_clk_i);
        arst_n_i = 1'b1;
        @(negedge ref_clk_i);
        sc_reset_values();
        sc_write_rw();
        sc_write_ro();
        sc_bad_reg();
        sc_link_b();
        end_of_test();
    end
endmodule : tb_two_wire_config_slave
`default_nettype wire

// ==== dv/twcs_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
module twcs_chk (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic scl,
    input wire logic m_sda_oe,
    input wire logic s_sda_oe,
    input wire logic sda
);
    import twcs_pkg::*;
    logic scl_p, sda_p, dir_rd, reg_ok, ign, start_w, rise_w, ack_w;
    logic [3:0] bitcnt;
    logic [1:0] byte_idx;
    logic [7:0] sh;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    // line events, oversampled by the fast clock
    assign start_w = scl & scl_p & sda_p & ~sda;
    assign rise_w = scl & ~scl_p;
    assign ack_w = rise_w & (bitcnt == 4'h8);
    // bit and byte position in the frame; rise 9 is the ack slot
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            scl_p <= 1'b1;
            sda_p <= 1'b1;
            dir_rd <= 1'b0;
            reg_ok <= 1'b0;
            ign <= 1'b0;
            bitcnt <= 4'h0;
            byte_idx <= 2'h0;
            sh <= 8'h00;
        end else begin
            scl_p <= scl;
            sda_p <= sda;
            if (start_w) begin
                bitcnt <= 4'h0;
                byte_idx <= 2'h0;
                ign <= 1'b0;
            end else if (rise_w) begin
                bitcnt <= (bitcnt == 4'h9) ? 4'h1 : bitcnt + 4'h1;
                if (bitcnt == 4'h9 && byte_idx != 2'h3) byte_idx <= byte_idx + 2'h1;
                if (bitcnt != 4'h8) sh <= {sh[6:0], sda};
                if (ack_w && byte_idx == 2'h0) dir_rd <= sh[0];
                if (ack_w && byte_idx == 2'h1) reg_ok <= ~sda;
                // a refused byte silences the slave until the next start
                if (ack_w && sda && (byte_idx == 2'h0 || !dir_rd)) ign <= 1'b1;
            end
        end
    end
    AST_OE_ON_SCL_LOW: assert property ($changed(s_sda_oe) |-> !scl)
        else $error("slave data enable moved while clock high");
    AST_ADDR_ACK: assert property (ack_w && byte_idx == 2'h0 |-> sda == (sh[7:1] != SLV_ADDR))
        else $error("address byte acknowledge wrong");
    AST_REG_ACK: assert property (ack_w && byte_idx == 2'h1 && !dir_rd && !ign |-> sda == (sh[7:5] != REG_HI_ZERO))
        else $error("register byte acknowledge wrong");
    AST_DATA_ACK: assert property (ack_w && byte_idx == 2'h2 && !dir_rd && reg_ok |-> !sda)
        else $error("write data byte not acknowledged");
    AST_OE_SLOTS: assert property (s_sda_oe |-> bitcnt >= 4'h8 || (dir_rd && byte_idx == 2'h1))
        else $error("slave drives data outside ack or read slots");
    AST_RD_RELEASE: assert property (ack_w && byte_idx == 2'h1 && dir_rd |-> !s_sda_oe && m_sda_oe)
        else $error("read data ack slot not left to the master");
    AST_SCL_LOW_TIME: assert property ($fell(scl) |-> !scl [*8] ##1 !scl ##1 !scl ##1 scl)
        else $error("serial clock low time not ten cycles");
    AST_IGNORE_REST: assert property (ign |-> !s_sda_oe)
        else $error("slave drives data after refusing the frame");
endmodule : twcs_chk
`default_nettype wire

// ==== rtl/twcs_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface twcs_if;
    logic scl;
    logic m_sda_oe;
    logic s_sda_oe;
    logic sda;
    // open-drain data line with pull-up: any enable pulls it low
    assign sda = (m_sda_oe | s_sda_oe) ? 1'h0 : 1'h1;
    modport master (output scl, output m_sda_oe, input sda);
    modport slave (input scl, input sda, output s_sda_oe);
endinterface : twcs_if
`default_nettype wire

// ==== rtl/twcs_master.sv ====
`timescale 1ns/1ns
`default_nettype none
module twcs_master (
    twcs_if.master link,
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire twcs_pkg::twcs_mode_t req_mode_i,
    input wire logic [7:0] req_reg_i,
    input wire logic [7:0] req_wdata_i,
    output logic done_o,
    output logic nack_o,
    output logic [7:0] rdata_o
);
    import twcs_pkg::*;

    // step sequence of each request kind
    function automatic twcs_op_t op_of(input twcs_mode_t m, input logic [2:0] s);
        twcs_op_t o;
        o = OP_TX;
        if (s == 3'h0) o = OP_START;
        else if (m == MODE_WR && s == 3'h4) o = OP_STOP;
        else if (m == MODE_RD_PTR && s == 3'h3) o = OP_START;
        else if (m == MODE_RD_PTR && s == 3'h5) o = OP_RX;
        else if (m == MODE_RD_PTR && s == 3'h6) o = OP_STOP;
        else if (m == MODE_RD_CUR && s == 3'h2) o = OP_RX;
        else if (m == MODE_RD_CUR && s == 3'h3) o = OP_STOP;
        return o;
    endfunction : op_of

    // step index of the stop, target of a refused byte
    function automatic logic [2:0] last_of(input twcs_mode_t m);
        return (m == MODE_WR) ? 3'h4 : (m == MODE_RD_PTR) ? 3'h6 : 3'h3;
    endfunction : last_of

    // byte sent at a transmit step
    function automatic logic [7:0] byte_of(input twcs_mode_t m, input logic [2:0] s,
                                           input logic [7:0] r, input logic [7:0] w);
        logic [7:0] b;
        b = {SLV_ADDR, DIR_WR};
        if (m == MODE_RD_CUR || (m == MODE_RD_PTR && s == 3'h4)) b = {SLV_ADDR, DIR_RD};
        else if (s == 3'h2) b = r;
        else if (s == 3'h3) b = w;
        return b;
    endfunction : byte_of

    twcs_mst_t st_q, st_d;
    twcs_mode_t mode_q, mode_d;
    logic [2:0] step_q, step_d, div_q, div_d;
    logic [3:0] bit_q, bit_d;
    logic [1:0] ph_q, ph_d;
    logic scl_q, scl_d, oe_q, oe_d, done_q, done_d, nack_q, nack_d;
    logic [7:0] reg_q, reg_d, wd_q, wd_d, rx_q, rx_d, rdata_q, rdata_d, cur;
    logic sda_s1_q, sda_s2_q;
    twcs_op_t op;

    // line level comes back from the pin: two flops before use
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sda_s1_q <= 1'h1;
            sda_s2_q <= 1'h1;
        end else begin
            sda_s1_q <= link.sda;
            sda_s2_q <= sda_s1_q;
        end
    end

    // quarter-bit sequencer: scl is divided down, not a second domain
    always_comb begin
        st_d = st_q;
        mode_d = mode_q;
        step_d = step_q;
        bit_d = bit_q;
        ph_d = ph_q;
        scl_d = scl_q;
        oe_d = oe_q;
        done_d = 1'h0;
        nack_d = nack_q;
        reg_d = reg_q;
        wd_d = wd_q;
        rx_d = rx_q;
        rdata_d = rdata_q;
        div_d = (div_q == QUARTER_END) ? 3'h0 : div_q + 3'h1;
        op = op_of(mode_q, step_q);
        cur = byte_of(mode_q, step_q, reg_q, wd_q);
        if (st_q == M_IDLE) begin
            scl_d = 1'h1;
            oe_d = 1'h0;
            div_d = 3'h0;
            if (req_valid_i) begin
                st_d = M_RUN;
                mode_d = req_mode_i;
                reg_d = req_reg_i;
                wd_d = req_wdata_i;
                step_d = 3'h0;
                bit_d = 4'h0;
                ph_d = 2'h0;
                nack_d = 1'h0;
            end
        end else if (div_q == QUARTER_END) begin
            ph_d = ph_q + 2'h1;
            if (ph_q == 2'h1) scl_d = 1'h1;
            unique case (op)
                OP_START: begin
                    if (ph_q == 2'h0) oe_d = 1'h0;
                    if (ph_q == 2'h2) oe_d = 1'h1;
                    if (ph_q == 2'h3) begin
                        scl_d = 1'h0;
                        step_d = step_q + 3'h1;
                    end
                end
                OP_TX, OP_RX: begin
                    if (ph_q == 2'h0) begin
                        if (bit_q == BIT_ACK) oe_d = (op == OP_RX);
                        else oe_d = (op == OP_TX) && !cur[3'(BIT_LAST - bit_q)];
                    end
                    if (ph_q == 2'h2) begin
                        if (op == OP_TX && bit_q == BIT_ACK && sda_s2_q) nack_d = 1'h1;
                        if (op == OP_RX && bit_q != BIT_ACK) rx_d = {rx_q[6:0], sda_s2_q};
                    end
                    if (ph_q == 2'h3) begin
                        scl_d = 1'h0;
                        bit_d = bit_q + 4'h1;
                        if (bit_q == BIT_ACK) begin
                            bit_d = 4'h0;
                            step_d = nack_q ? last_of(mode_q) : step_q + 3'h1;
                        end
                    end
                end
                OP_STOP: begin
                    if (ph_q == 2'h0) oe_d = 1'h1;
                    if (ph_q == 2'h2) oe_d = 1'h0;
                    if (ph_q == 2'h3) begin
                        st_d = M_IDLE;
                        done_d = 1'h1;
                        rdata_d = rx_q;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_q <= M_IDLE;
            mode_q <= MODE_WR;
            step_q <= 3'h0;
            bit_q <= 4'h0;
            ph_q <= 2'h0;
            div_q <= 3'h0;
            scl_q <= 1'h1;
            oe_q <= 1'h0;
            done_q <= 1'h0;
            nack_q <= 1'h0;
            reg_q <= 8'h00;
            wd_q <= 8'h00;
            rx_q <= 8'h00;
            rdata_q <= 8'h00;
        end else begin
            st_q <= st_d;
            mode_q <= mode_d;
            step_q <= step_d;
            bit_q <= bit_d;
            ph_q <= ph_d;
            div_q <= div_d;
            scl_q <= scl_d;
            oe_q <= oe_d;
            done_q <= done_d;
            nack_q <= nack_d;
            reg_q <= reg_d;
            wd_q <= wd_d;
            rx_q <= rx_d;
            rdata_q <= rdata_d;
        end
    end

    assign req_ready_o = (st_q == M_IDLE);
    assign done_o = done_q;
    assign nack_o = nack_q;
    assign rdata_o = rdata_q;
    assign link.scl = scl_q;
    assign link.m_sda_oe = oe_q;
endmodule : twcs_master
`default_nettype wire

// ==== rtl/twcs_pkg.sv ====
package twcs_pkg;
    // link addressing and register bank shape
    localparam logic [6:0] SLV_ADDR = 7'h3F;
    localparam logic DIR_RD = 1'h1;
    localparam logic DIR_WR = 1'h0;
    localparam int NUM_REGS = 32;
    localparam int AW = 5;
    localparam logic [AW-1:0] RO_LAST = 5'h0B;
    localparam logic [2:0] REG_HI_ZERO = 3'h0;
    // bit slots inside one byte frame
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    // identity bytes: values are arbitrary
    localparam logic [7:0] ID_VEND_LO = 8'hA1;
    localparam logic [7:0] ID_VEND_HI = 8'hB2;
    localparam logic [7:0] ID_DEV_LO = 8'hC3;
    localparam logic [7:0] ID_DEV_HI = 8'hD4;
    localparam logic [7:0] ID_REV = 8'h01;
    localparam logic [7:0] FREQ_LO = 8'h08;
    localparam logic [7:0] FREQ_HI = 8'h87;
    // serial clock generation at the master
    localparam int CLK_NS = 4;
    localparam int SCL_QUARTER_NS = 20;
    localparam int SCL_QUARTER_CYC = (SCL_QUARTER_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [2:0] QUARTER_END = 3'(SCL_QUARTER_CYC - 1);
    // slave receive states, gray along address, register, data
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_ADDR = 3'h1,
        S_REG = 3'h3,
        S_WDAT = 3'h2,
        S_RDAT = 3'h6
    } twcs_sst_t;
    // master request kinds
    typedef enum logic [1:0] {
        MODE_WR = 2'h0,
        MODE_RD_PTR = 2'h1,
        MODE_RD_CUR = 2'h3
    } twcs_mode_t;
    typedef enum logic [1:0] {
        OP_START = 2'h0,
        OP_TX = 2'h1,
        OP_RX = 2'h3,
        OP_STOP = 2'h2
    } twcs_op_t;
    typedef enum logic {
        M_IDLE = 1'h0,
        M_RUN = 1'h1
    } twcs_mst_t;

    // power-up contents of each register
    function automatic logic [7:0] twcs_rst_val(input logic [AW-1:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            5'h00: v = ID_VEND_LO;
            5'h01: v = ID_VEND_HI;
            5'h02: v = ID_DEV_LO;
            5'h03: v = ID_DEV_HI;
            5'h04: v = ID_REV;
            5'h05: v = FREQ_LO;
            5'h06: v = FREQ_HI;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : twcs_rst_val
endpackage : twcs_pkg

// ==== rtl/twcs_slave.sv ====
// Function
// - slave only; clock input, data line two-way
// - answer only the fixed seven-bit address
// - thirty-two byte registers behind the link
// - read-only registers ignore writes
// - sequencing runs on serial clock edges and data line falls
// - single byte per access, no address advance
// - address-only read returns latched register
// - pointer write, repeated start, then read
// - master completes one access between reads
// - every byte travels most significant first
// - accept ack or nack after read data
// - pointer read: three slave acks, master ack, stop
// - write: address, register, data, three acks
// - master forms register byte with three leading zeros; twcs_master sends req_reg_i unchanged
// - bit after address: one reads, zero writes
`timescale 1ns/1ns
`default_nettype none
module twcs_slave (
    twcs_if.slave link,
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    output logic cfg_wr_o,
    output logic [twcs_pkg::AW-1:0] cfg_addr_o,
    output logic [7:0] cfg_data_o
);
    import twcs_pkg::*;

    // writable from the link unless in the read-only block, 0 to RO_LAST
    function automatic logic is_rw(input logic [AW-1:0] a);
        return a > RO_LAST;
    endfunction : is_rw

    logic st_tog_q, st_tog_d;
    logic seen_q, seen_d;
    logic start_pend;
    twcs_sst_t st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d, byte_in;
    logic ack_q, ack_d, rd_q, rd_d;
    logic [AW-1:0] ptr_q, ptr_d;
    logic [7:0] rdat_q, rdat_d;
    logic [7:0] regs_q [NUM_REGS];
    logic [7:0] regs_d [NUM_REGS];
    logic wr_tog_q, wr_tog_d;
    logic [AW-1:0] wa_q, wa_d;
    logic [7:0] wd_q, wd_d;
    logic oe_q, oe_d;
    logic ws1_q, ws2_q, ws3_q;
    logic cw_q, cw_d;
    logic [AW-1:0] ca_q, ca_d;
    logic [7:0] cd_q, cd_d;

    // start = data falls while clock high; caught on the data line itself,
    // since the sequencing runs on serial clock edges, not on ref_clk_i
    always_comb begin
        st_tog_d = link.scl ? ~st_tog_q : st_tog_q;
    end

    always_ff @(negedge link.sda or negedge arst_n_i) begin
        if (!arst_n_i) st_tog_q <= 1'h0;
        else st_tog_q <= st_tog_d;
    end

    // toggle settles three quarters of a bit before the next rising clock
    assign start_pend = st_tog_q ^ seen_q;
    assign byte_in = {sh_q[6:0], link.sda};

    // receive side: sample data on each rising serial clock
    always_comb begin
        seen_d = seen_q;
        st_d = st_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        ack_d = ack_q;
        rd_d = rd_q;
        ptr_d = ptr_q;
        rdat_d = rdat_q;
        regs_d = regs_q;
        wr_tog_d = wr_tog_q;
        wa_d = wa_q;
        wd_d = wd_q;
        if (start_pend) begin
            // first address bit rides on the first edge after start
            seen_d = st_tog_q;
            st_d = S_ADDR;
            cnt_d = 4'h1;
            sh_d = byte_in;
            ack_d = 1'h0;
        end else if (st_q != S_IDLE) begin
            if (cnt_q != BIT_ACK) begin
                cnt_d = cnt_q + 4'h1;
                sh_d = byte_in;
                if (cnt_q == BIT_LAST) begin
                    if (st_q == S_ADDR) begin
                        ack_d = (byte_in[7:1] == SLV_ADDR);
                        rd_d = (byte_in[0] == DIR_RD);
                    end else if (st_q == S_REG) begin
                        ack_d = (byte_in[7:5] == REG_HI_ZERO);
                    end else if (st_q == S_WDAT) begin
                        ack_d = 1'h1;
                    end else begin
                        ack_d = 1'h0;
                    end
                end
            end else begin
                // ack slot: the master samples the answer on this edge
                cnt_d = 4'h0;
                ack_d = 1'h0;
                st_d = S_IDLE;
                if (ack_q) begin
                    if (st_q == S_ADDR) begin
                        if (rd_q) begin
                            st_d = S_RDAT;
                            rdat_d = regs_q[ptr_q];
                        end else begin
                            st_d = S_REG;
                        end
                    end else if (st_q == S_REG) begin
                        ptr_d = sh_q[AW-1:0];
                        st_d = S_WDAT;
                    end else if (st_q == S_WDAT && is_rw(ptr_q)) begin
                        regs_d[ptr_q] = sh_q;
                        wr_tog_d = ~wr_tog_q;
                        wa_d = ptr_q;
                        wd_d = sh_q;
                    end
                end
                // after one data byte the frame is ignored to its stop
            end
        end
    end

    // whole bank under reset; read-only entries never change after
    always_ff @(posedge link.scl or negedge arst_n_i) begin
        if (!arst_n_i) begin
            seen_q <= 1'h0;
            st_q <= S_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            ack_q <= 1'h0;
            rd_q <= 1'h0;
            ptr_q <= 5'h00;
            rdat_q <= 8'h00;
            wr_tog_q <= 1'h0;
            wa_q <= 5'h00;
            wd_q <= 8'h00;
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_q[i] <= twcs_rst_val(AW'(i));
            end
        end else begin
            seen_q <= seen_d;
            st_q <= st_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            ack_q <= ack_d;
            rd_q <= rd_d;
            ptr_q <= ptr_d;
            rdat_q <= rdat_d;
            wr_tog_q <= wr_tog_d;
            wa_q <= wa_d;
            wd_q <= wd_d;
            regs_q <= regs_d;
        end
    end

    // drive side: change data only while the clock is low
    always_comb begin
        oe_d = 1'h0;
        if (!start_pend) begin
            if (cnt_q == BIT_ACK && ack_q) begin
                oe_d = 1'h1;
            end else if (st_q == S_RDAT && cnt_q != BIT_ACK) begin
                oe_d = !rdat_q[3'(BIT_LAST - cnt_q)];
            end
        end
    end

    always_ff @(negedge link.scl or negedge arst_n_i) begin
        if (!arst_n_i) oe_q <= 1'h0;
        else oe_q <= oe_d;
    end

    // only the data line has a driver here; clock is never driven
    assign link.s_sda_oe = oe_q;

    // write event to the core clock: toggle through two flops,
    // the address and data are stable long before it arrives
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ws1_q <= 1'h0;
            ws2_q <= 1'h0;
            ws3_q <= 1'h0;
        end else begin
            ws1_q <= wr_tog_q;
            ws2_q <= ws1_q;
            ws3_q <= ws2_q;
        end
    end

    always_comb begin
        cw_d = ws2_q ^ ws3_q;
        ca_d = ca_q;
        cd_d = cd_q;
        if (cw_d) begin
            ca_d = wa_q;
            cd_d = wd_q;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cw_q <= 1'h0;
            ca_q <= 5'h00;
            cd_q <= 8'h00;
        end else begin
            cw_q <= cw_d;
            ca_q <= ca_d;
            cd_q <= cd_d;
        end
    end

    assign cfg_wr_o = cw_q;
    assign cfg_addr_o = ca_q;
    assign cfg_data_o = cd_q;
endmodule : twcs_slave
`default_nettype wire
